// [bench/tb.sv]
// Self-checking bench for the windowed watchdog timer.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.vh"
module tb;
	logic clk_i = 1'b0, rst_i = 1'b1, dbg = 1'b0;
	logic cyc, stb, we, ack, nmi, srst, irq;
	logic [3:0] adr, sel;
	logic [31:0] wd, rd, q, frz;
	int n_fail = 0, n_tests = 0, ticks = 0;
	initial forever #50 clk_i = ~clk_i;
	wdt_cpu_model cpu_u (.clk_i(clk_i), .ack_i(ack), .rdat_i(rd), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(adr), .dat_o(wd), .sel_o(sel));
	wdt_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .dat_i(wd), .sel_i(sel), .dat_o(rd), .ack_o(ack), .debug_mode_i(dbg),
		.watchdog_timeout_nmi_o(nmi), .watchdog_system_reset_o(srst), .irq_o(irq));
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task chb(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		cpu_u.xfer(1'b1, a, d, q);
	endtask
	task rdc(input logic [3:0] a, input logic [31:0] e);
		cpu_u.xfer(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task hold(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task rst_dut;
		rst_i <= 1'b1;
		hold(12);
		rst_i <= 1'b0;
	endtask
	task arm(input logic [31:0] rel, input logic [31:0] ctl);
		rst_dut;
		wr(`WDT_ADR_RELOAD, rel);
		wr(`WDT_ADR_CTRL, ctl);
		wr(`WDT_ADR_SERVICE, {24'h0, `WDT_SERVICE_KEY});
	endtask
	task wrap_up;
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		ticks++;
		if (ticks == 60000) begin
			n_fail++;
			wrap_up;
		end
	end
	initial begin
		arm(32'hFE, 32'h1);
		cpu_u.xfer(1'b0, `WDT_ADR_COUNT, 32'h0, q);
		chk({24'h0, q[15:8]}, 32'hFE);
		rdc(4'h9, 32'h0);
		hold(960);
		chb(nmi, 1'b0);
		hold(70);
		chb(nmi, 1'b1);
		hold(70);
		chb(srst, 1'b0);
		hold(40);
		chb(srst, 1'b1);
		cpu_u.xfer(1'b0, `WDT_ADR_STATUS, 32'h0, q);
		chk(q & 32'h3, 32'h1);
		wr(`WDT_ADR_IRQ_EN, 32'h1);
		hold(2);
		chb(irq, 1'b1);
		wr(`WDT_ADR_IRQ_CLR, 32'h1);
		hold(2);
		chb(irq, 1'b0);
		arm(32'h0, 32'h5);
		wr(`WDT_ADR_WINDOW, 32'h1);
		rst_dut;
		rdc(`WDT_ADR_WINDOW, 32'h0);
		wr(`WDT_ADR_WINDOW, 32'h1);
		wr(`WDT_ADR_CTRL, 32'h5);
		hold(600);
		wr(`WDT_ADR_SERVICE, {24'h0, `WDT_SERVICE_KEY});
		rdc(`WDT_ADR_STATUS, 32'h0);
		wr(`WDT_ADR_SERVICE, {24'h0, `WDT_SERVICE_KEY});
		rdc(`WDT_ADR_STATUS, 32'h6);
		hold(120);
		chb(srst, 1'b1);
		chb(nmi, 1'b0);
		arm(32'hFF, 32'h1);
		dbg <= 1'b1;
		hold(2000);
		chb(nmi, 1'b0);
		cpu_u.xfer(1'b0, `WDT_ADR_COUNT, 32'h0, frz);
		chk({24'h0, frz[15:8]}, 32'hFF);
		hold(100);
		rdc(`WDT_ADR_COUNT, frz);
		dbg <= 1'b0;
		hold(600);
		chb(nmi, 1'b1);
		arm(32'hFF, 32'h3);
		hold(32000);
		chb(nmi, 1'b0);
		hold(1200);
		chb(nmi, 1'b1);
		wrap_up;
	end
endmodule
`default_nettype wire

// [bench/wdt_cpu_model.sv]
// Software side of the watchdog: classic single Wishbone cycles.
`timescale 1ns/1ps
`default_nettype none
module wdt_cpu_model (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] rdat_i,
	output var logic cyc_o,
	output var logic stb_o,
	output var logic we_o,
	output var logic [3:0] adr_o,
	output var logic [31:0] dat_o,
	output var logic [3:0] sel_o
);
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 4'h0;
		dat_o = 32'h0;
		sel_o = 4'hF;
	end
	task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		dat_o <= d;
		sel_o <= 4'hF;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = rdat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		// Released data must not keep looking valid.
		dat_o <= ~d;
	endtask
endmodule
`default_nettype wire

// [bench/wdt_props.sv]
// Checker of the watchdog bus answers and timeout outputs.
`timescale 1ns/1ps
`default_nettype none
module wdt_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic debug_mode_i,
	input wire logic watchdog_timeout_nmi_o,
	input wire logic watchdog_system_reset_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence req_s;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence frozen_s;
		debug_mode_i [*6] ##0 !watchdog_timeout_nmi_o;
	endsequence
	ack_taken_a: assert property (req_s |=> ack_o) else $error("no ack");
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
	ack_idle_a: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("stray ack");
	dat_quiet_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("data without ack");
	nmi_hold_a: assert property (watchdog_timeout_nmi_o |=> watchdog_timeout_nmi_o)
		else $error("nmi dropped");
	reset_hold_a: assert property (watchdog_system_reset_o |=> watchdog_system_reset_o)
		else $error("reset dropped");
	// Prewarning is 30 hex counts of at least two clocks each, so 90 cycles is a safe floor.
	prewarn_len_a: assert property ($rose(watchdog_system_reset_o) && watchdog_timeout_nmi_o
		|-> $past(watchdog_timeout_nmi_o, 90)) else $error("prewarning short");
	debug_freeze_a: assert property (frozen_s |=> !watchdog_timeout_nmi_o)
		else $error("timeout in debug");
endmodule
bind wdt_top wdt_props props_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
	.debug_mode_i(debug_mode_i), .watchdog_timeout_nmi_o(watchdog_timeout_nmi_o),
	.watchdog_system_reset_o(watchdog_system_reset_o), .irq_o(irq_o));
`default_nettype wire

// [core/wdt_defines.vh]
// Constants for the windowed watchdog timer: register map, fields and timing.
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH
`define WDT_ADR_CTRL 4'h0
`define WDT_ADR_RELOAD 4'h1
`define WDT_ADR_WINDOW 4'h2
`define WDT_ADR_SERVICE 4'h3
`define WDT_ADR_COUNT 4'h4
`define WDT_ADR_STATUS 4'h5
`define WDT_ADR_IRQ_EN 4'h6
`define WDT_ADR_IRQ_CLR 4'h7
`define WDT_CTRL_ENABLE 0
`define WDT_CTRL_INSEL 1
`define WDT_CTRL_WINEN 2
`define WDT_ST_TIMEOUT 0
`define WDT_ST_INVALID 1
`define WDT_ST_PREWARN 2
`define WDT_SERVICE_KEY 8'hA5
`define WDT_DIV_SLOW 7'h7F
`define WDT_DIV_FAST 7'h01
`define WDT_PREWARN_COUNTS 8'h30
`define WDT_ZERO_BYTE 8'h00
`define WDT_FULL_BYTE 8'hFF
`define WDT_ONE_BYTE 8'h01
`define WDT_BYTE_MSB 7
`define WDT_EVT_MSB 2
`define WDT_CNT_MSB 15
`define WDT_LANE0 0
`define WDT_EVT_NONE 3'h0
`define WDT_WORD_ZERO 32'h00000000
`endif

// [core/wdt_rate_div.v]
// Count rate enable generator for the watchdog timer.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.vh"
module wdt_rate_div (
	input wire clk_i,
	input wire rst_i,
	input wire run_i,
	input wire slow_i,
	output reg tick_o
);
	reg [6:0] cnt_reg;
	wire [6:0] limit;
	assign limit = slow_i ? `WDT_DIV_SLOW : `WDT_DIV_FAST;
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= 7'h00;
			tick_o <= 1'b0;
		end else if (!run_i) begin
			tick_o <= 1'b0;
		end else if (cnt_reg >= limit) begin
			cnt_reg <= 7'h00;
			tick_o <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 7'h01;
			tick_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [core/wdt_sync.v]
// Two flip-flop synchroniser for a level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module wdt_sync (
	input wire clk_i,
	input wire rst_i,
	input wire d_i,
	output reg q_o
);
	reg meta_reg;
	always @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= 1'b0;
			q_o <= 1'b0;
		end else begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// [core/wdt_top.v]
// Windowed watchdog timer with a classic Wishbone register slave.
//
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.vh"
module wdt_top (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [3:0] adr_i,
	input wire [31:0] dat_i,
	input wire [3:0] sel_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	input wire debug_mode_i,
	output reg watchdog_timeout_nmi_o,
	output reg watchdog_system_reset_o,
	output reg irq_o
);
	// Once fired the block stays there, since only the device reset may end it.
	localparam ST_WATCH = 3'h1;
	localparam ST_WARN = 3'h2;
	localparam ST_FIRED = 3'h4;

	reg enable_reg;
	reg enable_next;
	reg insel_reg;
	reg insel_next;
	reg winen_reg;
	reg winen_next;
	reg [7:0] watchdog_reload_high_reg;
	reg [7:0] watchdog_reload_high_next;
	reg [7:0] watchdog_window_bound_reg;
	reg [7:0] watchdog_window_bound_next;
	reg [7:0] cnt_lo_reg;
	reg [7:0] cnt_lo_next;
	reg [7:0] cnt_hi_reg;
	reg [7:0] cnt_hi_next;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [7:0] pw_cnt_reg;
	reg [7:0] pw_cnt_next;
	reg nmi_next;
	reg sys_rst_next;
	reg [2:0] status_reg;
	reg [2:0] status_next;
	reg [2:0] irq_en_reg;
	reg [2:0] irq_en_next;
	reg irq_next;
	reg ack_next;
	reg [31:0] dat_next;
	reg [2:0] events;
	reg [31:0] rd_data;
	wire debug_sync;
	wire tick;
	wire bus_req;
	wire wr_lane0;
	wire service;
	wire clear_req;
	wire watching;
	wire in_window;
	wire reload_ok;
	wire invalid;
	wire overflow;

	// Address decode is shared by the service and clear strobes.
	function addr_hit;
		input [3:0] adr;
		input [3:0] want;
		begin
			addr_hit = (adr == want);
		end
	endfunction

	function [7:0] byte_inc;
		input [7:0] value;
		begin
			byte_inc = value + `WDT_ONE_BYTE;
		end
	endfunction

	function byte_full;
		input [7:0] value;
		begin
			byte_full = (value == `WDT_FULL_BYTE);
		end
	endfunction

	wdt_sync u_dbg_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(debug_mode_i),
		.q_o(debug_sync)
	);

	// Debug mode stops the count-rate divider so the count holds.
	wdt_rate_div u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(enable_reg & ~debug_sync & ~watchdog_system_reset_o),
		.slow_i(insel_reg),
		.tick_o(tick)
	);

	assign bus_req = cyc_i & stb_i & ~ack_o;
	assign wr_lane0 = bus_req & we_i & sel_i[`WDT_LANE0];
	// A service needs a key so that a stray write cannot refresh the timer.
	assign service = wr_lane0 & addr_hit(adr_i, `WDT_ADR_SERVICE) &
		(dat_i[`WDT_BYTE_MSB:0] == `WDT_SERVICE_KEY);
	assign clear_req = wr_lane0 & addr_hit(adr_i, `WDT_ADR_IRQ_CLR);
	assign watching = (state_reg == ST_WATCH);
	assign in_window = winen_reg &
		({cnt_hi_reg, cnt_lo_reg} < {watchdog_window_bound_reg, `WDT_ZERO_BYTE});
	assign reload_ok = service & watching & ~in_window;
	assign invalid = service & watching & in_window;
	// A service in the overflow cycle wins, so no timeout is flagged beside it.
	assign overflow = tick & watching & ~service & byte_full(cnt_lo_reg) &
		byte_full(cnt_hi_reg);

	always @* begin
		events = `WDT_EVT_NONE;
		events[`WDT_ST_TIMEOUT] = overflow;
		events[`WDT_ST_INVALID] = invalid;
		events[`WDT_ST_PREWARN] = overflow | invalid;
	end

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_WATCH: begin
				if (invalid | overflow) begin
					state_next = ST_WARN;
				end
			end
			ST_WARN: begin
				if (tick & (pw_cnt_reg == (`WDT_PREWARN_COUNTS - `WDT_ONE_BYTE))) begin
					state_next = ST_FIRED;
				end
			end
			ST_FIRED: begin
				state_next = ST_FIRED;
			end
			default: begin
				state_next = ST_WATCH;
			end
		endcase
	end

	always @* begin
		pw_cnt_next = pw_cnt_reg;
		if (state_reg == ST_WATCH) begin
			pw_cnt_next = `WDT_ZERO_BYTE;
		end else if ((state_reg == ST_WARN) & tick & (state_next == ST_WARN)) begin
			pw_cnt_next = byte_inc(pw_cnt_reg);
		end
	end

	always @* begin
		cnt_lo_next = cnt_lo_reg;
		cnt_hi_next = cnt_hi_reg;
		if (reload_ok) begin
			cnt_lo_next = `WDT_ZERO_BYTE;
			cnt_hi_next = watchdog_reload_high_reg;
		end else if (tick & watching & ~invalid) begin
			cnt_lo_next = byte_inc(cnt_lo_reg);
			if (byte_full(cnt_lo_reg)) begin
				cnt_hi_next = byte_inc(cnt_hi_reg);
			end
		end
	end

	always @* begin
		nmi_next = watchdog_timeout_nmi_o | overflow;
		sys_rst_next = (state_next == ST_FIRED);
	end

	// The reset output feeds the device reset tree, which also clears this block.
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_WATCH;
			cnt_lo_reg <= `WDT_ZERO_BYTE;
			cnt_hi_reg <= `WDT_ZERO_BYTE;
			pw_cnt_reg <= `WDT_ZERO_BYTE;
			watchdog_timeout_nmi_o <= 1'b0;
			watchdog_system_reset_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_lo_reg <= cnt_lo_next;
			cnt_hi_reg <= cnt_hi_next;
			pw_cnt_reg <= pw_cnt_next;
			watchdog_timeout_nmi_o <= nmi_next;
			watchdog_system_reset_o <= sys_rst_next;
		end
	end

	always @* begin
		enable_next = enable_reg;
		insel_next = insel_reg;
		winen_next = winen_reg;
		watchdog_reload_high_next = watchdog_reload_high_reg;
		watchdog_window_bound_next = watchdog_window_bound_reg;
		irq_en_next = irq_en_reg;
		if (wr_lane0) begin
			case (adr_i)
				`WDT_ADR_CTRL: begin
					enable_next = dat_i[`WDT_CTRL_ENABLE];
					insel_next = dat_i[`WDT_CTRL_INSEL];
					winen_next = dat_i[`WDT_CTRL_WINEN];
				end
				`WDT_ADR_RELOAD: begin
					watchdog_reload_high_next = dat_i[`WDT_BYTE_MSB:0];
				end
				`WDT_ADR_WINDOW: begin
					watchdog_window_bound_next = dat_i[`WDT_BYTE_MSB:0];
				end
				`WDT_ADR_IRQ_EN: begin
					irq_en_next = dat_i[`WDT_EVT_MSB:0];
				end
				default: begin
				end
			endcase
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			enable_reg <= 1'b0;
			insel_reg <= 1'b0;
			winen_reg <= 1'b0;
			watchdog_reload_high_reg <= `WDT_ZERO_BYTE;
			watchdog_window_bound_reg <= `WDT_ZERO_BYTE;
			irq_en_reg <= `WDT_EVT_NONE;
		end else begin
			enable_reg <= enable_next;
			insel_reg <= insel_next;
			winen_reg <= winen_next;
			watchdog_reload_high_reg <= watchdog_reload_high_next;
			watchdog_window_bound_reg <= watchdog_window_bound_next;
			irq_en_reg <= irq_en_next;
		end
	end

	// Status bits are sticky; a new event wins over a clear in the same cycle.
	always @* begin
		status_next = status_reg | events;
		if (clear_req) begin
			status_next = (status_reg & ~dat_i[`WDT_EVT_MSB:0]) | events;
		end
		irq_next = |(status_reg & irq_en_reg);
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			status_reg <= `WDT_EVT_NONE;
			irq_o <= 1'b0;
		end else begin
			status_reg <= status_next;
			irq_o <= irq_next;
		end
	end

	always @* begin
		rd_data = `WDT_WORD_ZERO;
		case (adr_i)
			`WDT_ADR_CTRL: begin
				rd_data[`WDT_CTRL_ENABLE] = enable_reg;
				rd_data[`WDT_CTRL_INSEL] = insel_reg;
				rd_data[`WDT_CTRL_WINEN] = winen_reg;
			end
			`WDT_ADR_RELOAD: begin
				rd_data[`WDT_BYTE_MSB:0] = watchdog_reload_high_reg;
			end
			`WDT_ADR_WINDOW: begin
				rd_data[`WDT_BYTE_MSB:0] = watchdog_window_bound_reg;
			end
			`WDT_ADR_COUNT: begin
				rd_data[`WDT_CNT_MSB:0] = {cnt_hi_reg, cnt_lo_reg};
			end
			`WDT_ADR_STATUS: begin
				rd_data[`WDT_EVT_MSB:0] = status_reg;
			end
			`WDT_ADR_IRQ_EN: begin
				rd_data[`WDT_EVT_MSB:0] = irq_en_reg;
			end
			default: begin
				rd_data = `WDT_WORD_ZERO;
			end
		endcase
	end

	always @* begin
		ack_next = bus_req;
		dat_next = `WDT_WORD_ZERO;
		if (bus_req) begin
			dat_next = rd_data;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= `WDT_WORD_ZERO;
		end else begin
			ack_o <= ack_next;
			dat_o <= dat_next;
		end
	end
endmodule
`default_nettype wire
